// File: src/serial_port_pkg.sv
// Purpose: shared types and constants for the multi-mode serial port
// Assumes: one system clock; every link pin is sampled by that clock
// Notes: spi and i2c timing counts are in half bit-clock steps; uart counts are whole bit-clock ticks

package serial_port_pkg;

   // operating modes of the port
   typedef enum logic [2:0]
   {
      MODE_SPI_M3 = 3'h0,
      MODE_SPI_M4 = 3'h1,
      MODE_SPI_S = 3'h2,
      MODE_I2C_M = 3'h3,
      MODE_UART = 3'h4
   } port_mode_t;

   // bit clock sources
   localparam logic [1:0] SRC_AUX = 2'h0;
   localparam logic [1:0] SRC_SUB = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h2;

   // slot positions in the pin synchroniser vector
   localparam int SYNC_W = 8;
   localparam int SY_AUX = 0;
   localparam int SY_SUB = 1;
   localparam int SY_EXT = 2;
   localparam int SY_SCK = 3;
   localparam int SY_SDI = 4;
   localparam int SY_STE = 5;
   localparam int SY_SCL = 6;
   localparam int SY_SDA = 7;

   // step counts
   localparam logic [4:0] SPI_LAST_HALF = 5'h0F;
   localparam logic [4:0] I2C_ACK_HALF = 5'h10;
   localparam logic [4:0] I2C_LAST_HALF = 5'h11;
   localparam logic [4:0] UART_STOP_BIT = 5'h09;
   localparam logic [4:0] UART_END_BIT = 5'h0A;
   localparam logic [4:0] STEP_ZERO = 5'h00;
   localparam logic [4:0] STEP_ONE = 5'h01;

   // enable pin is active low
   localparam logic STE_ACTIVE = 1'b0;

   typedef struct packed
   {
      port_mode_t mode;
      logic clock_polarity_sel;
      logic clock_phase_sel;
      logic enable_pin_role_sel;
      logic [1:0] clk_src;
   } port_cfg_t;

   typedef struct packed
   {
      logic tx_ready_flag;
      logic rx_full_flag;
      logic port_busy_flag;
      logic tx_complete_flag;
      logic clk_line_low_flag;
      logic rx_written_flag;
   } port_flags_t;

   typedef enum logic [5:0]
   {
      ST_IDLE = 6'h01,
      ST_SPI = 6'h02,
      ST_I2C_START = 6'h04,
      ST_I2C_BIT = 6'h08,
      ST_I2C_STOP = 6'h10,
      ST_UART = 6'h20
   } port_state_t;

   typedef struct packed
   {
      port_state_t fsm;
      logic [4:0] h;
      logic [7:0] txsh;
      logic [7:0] rxsh;
      logic [7:0] txbuf;
      logic [7:0] receive_buffer;
      logic txfull;
      logic tx_ready;
      logic rx_full;
      logic tx_cplt;
      logic rx_written;
      logic byte_stored;
      logic stop_pend;
      logic phase;
      logic sdo;
      logic scl_oe;
      logic sda_oe;
      logic txd;
      logic sel_clk_prev;
      logic sck_prev;
      logic scl_prev;
   } port_st_t;

   localparam port_st_t ST_RESET = '{fsm: ST_IDLE, tx_ready: 1'b1, txd: 1'b1, scl_prev: 1'b1,
      default: '0};

   typedef struct packed
   {
      logic [SYNC_W-1:0] meta;
      logic [SYNC_W-1:0] stable;
   } sync_st_t;

endpackage

// File: src/pin_sync.sv
// Purpose: two-stage synchroniser for every asynchronous link pin
// Assumes: pins change slower than core_clk
// Notes: the first stage feeds only the second stage

`timescale 1ns/1ps
`default_nettype none

module pin_sync
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [serial_port_pkg::SYNC_W-1:0] pins,
   output logic [serial_port_pkg::SYNC_W-1:0] pins_sync
);

   serial_port_pkg::sync_st_t q;
   serial_port_pkg::sync_st_t n;

   // shift pins through two flops
   always_comb
   begin
      n.meta = pins;
      n.stable = q.meta;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign pins_sync = q.stable;

endmodule

`default_nettype wire

// File: src/serial_port.sv
// Purpose: multi-mode serial port: spi master/slave, i2c master receive, uart transmit
// Assumes: bit clocks and link pins are asynchronous and sampled by core_clk
// Notes: one byte of transmit and receive buffering; flags are set in core_clk domain

`timescale 1ns/1ps
`default_nettype none

module serial_port
(
   input wire logic core_clk,
   input wire logic srst,
   input wire serial_port_pkg::port_cfg_t cfg,
   input wire logic soft_reset_bit,
   input wire logic [7:0] tx_data,
   input wire logic tx_write,
   input wire logic rx_read,
   input wire logic tx_cplt_clr,
   input wire logic i2c_start,
   input wire logic i2c_stop,
   output logic [7:0] rx_data,
   output serial_port_pkg::port_flags_t flags,
   output logic clk_request,
   input wire logic aux_clk,
   input wire logic sub_main_clock,
   input wire logic external_clock_input,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   input wire logic slave_tx_enable_pin_in,
   output logic slave_tx_enable_pin_out,
   output logic slave_tx_enable_pin_oe,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic uart_txd
);

   serial_port_pkg::port_st_t q;
   serial_port_pkg::port_st_t n;
   logic [serial_port_pkg::SYNC_W-1:0] s;
   logic [1:0] src;
   logic sel_clk;
   logic tick;
   logic sck_edge;
   logic scl_fall;
   logic ste_act;
   logic is_master;
   logic guard;
   logic spi_edge;
   logic leading;
   logic stop_now;

   // every link pin and bit clock passes two flops first
   pin_sync u_sync
   (
      .core_clk(core_clk),
      .srst(srst),
      .pins({sda_in, scl_in, slave_tx_enable_pin_in, sdi, sck_in, external_clock_input,
         sub_main_clock, aux_clk}),
      .pins_sync(s)
   );

   // bit clock selection; external input is not allowed as i2c master source
   always_comb
   begin
      src = cfg.clk_src;
      if (cfg.mode == serial_port_pkg::MODE_I2C_M && src == serial_port_pkg::SRC_EXT)
      begin
         src = serial_port_pkg::SRC_AUX;
      end
      case (src)
         serial_port_pkg::SRC_SUB: sel_clk = s[serial_port_pkg::SY_SUB];
         serial_port_pkg::SRC_EXT: sel_clk = s[serial_port_pkg::SY_EXT];
         default: sel_clk = s[serial_port_pkg::SY_AUX];
      endcase
   end

   // edge finding on synchronised levels only
   assign tick = sel_clk & ~q.sel_clk_prev;
   assign sck_edge = s[serial_port_pkg::SY_SCK] ^ q.sck_prev;
   assign scl_fall = q.scl_prev & ~s[serial_port_pkg::SY_SCL];
   assign ste_act = s[serial_port_pkg::SY_STE] == serial_port_pkg::STE_ACTIVE;
   assign is_master = cfg.mode == serial_port_pkg::MODE_SPI_M3 ||
      cfg.mode == serial_port_pkg::MODE_SPI_M4;
   assign guard = cfg.mode == serial_port_pkg::MODE_SPI_M4 && !cfg.enable_pin_role_sel;
   assign spi_edge = is_master ? tick : (sck_edge && ste_act);
   assign leading = is_master ? ~q.phase :
      (s[serial_port_pkg::SY_SCK] != cfg.clock_polarity_sel);
   assign stop_now = q.stop_pend | i2c_stop;

   // next state; clears come first so a same-cycle set wins
   always_comb
   begin
      n = q;
      n.sel_clk_prev = sel_clk;
      n.sck_prev = s[serial_port_pkg::SY_SCK];
      n.scl_prev = s[serial_port_pkg::SY_SCL];
      if (rx_read)
      begin
         n.rx_full = 1'b0;
         n.rx_written = 1'b0;
      end
      if (tx_cplt_clr)
      begin
         n.tx_cplt = 1'b0;
      end
      if (cfg.mode == serial_port_pkg::MODE_I2C_M && scl_fall)
      begin
         n.rx_written = 1'b1;
      end
      case (q.fsm)
         serial_port_pkg::ST_IDLE:
         begin
            n.h = serial_port_pkg::STEP_ZERO;
            n.byte_stored = 1'b0;
            n.phase = 1'b0;
            if (cfg.mode == serial_port_pkg::MODE_I2C_M)
            begin
               if (i2c_start)
               begin
                  n.stop_pend = 1'b0;
                  n.fsm = serial_port_pkg::ST_I2C_START;
               end
            end
            // guard mode waits for the master-active level before loading
            else if (q.txfull && !(guard && !ste_act))
            begin
               n.txsh = q.txbuf;
               n.txfull = 1'b0;
               n.tx_ready = 1'b1;
               n.sdo = q.txbuf[7];
               n.fsm = (cfg.mode == serial_port_pkg::MODE_UART) ? serial_port_pkg::ST_UART :
                  serial_port_pkg::ST_SPI;
            end
         end
         serial_port_pkg::ST_SPI:
         begin
            // byte is dropped, not resumed; software must write it again
            if (guard && !ste_act)
            begin
               n.fsm = serial_port_pkg::ST_IDLE;
               n.phase = 1'b0;
            end
            else if (spi_edge)
            begin
               n.phase = ~q.phase;
               if (leading ^ cfg.clock_phase_sel)
               begin
                  n.rxsh = {q.rxsh[6:0], s[serial_port_pkg::SY_SDI]};
               end
               else if (q.h != serial_port_pkg::STEP_ZERO)
               begin
                  n.txsh = {q.txsh[6:0], 1'b0};
                  n.sdo = q.txsh[6];
               end
               n.h = q.h + serial_port_pkg::STEP_ONE;
               if (q.h == serial_port_pkg::SPI_LAST_HALF)
               begin
                  n.receive_buffer = n.rxsh;
                  n.rx_full = 1'b1;
                  n.phase = 1'b0;
                  n.fsm = serial_port_pkg::ST_IDLE;
               end
            end
         end
         serial_port_pkg::ST_UART:
         begin
            if (tick)
            begin
               n.h = q.h + serial_port_pkg::STEP_ONE;
               if (q.h == serial_port_pkg::STEP_ZERO)
               begin
                  n.txd = 1'b0;
               end
               else if (q.h < serial_port_pkg::UART_STOP_BIT)
               begin
                  n.txd = q.txsh[0];
                  n.txsh = {1'b0, q.txsh[7:1]};
               end
               else if (q.h == serial_port_pkg::UART_STOP_BIT)
               begin
                  n.txd = 1'b1;
               end
               else
               begin
                  n.tx_cplt = 1'b1;
                  n.fsm = serial_port_pkg::ST_IDLE;
               end
            end
         end
         serial_port_pkg::ST_I2C_START:
         begin
            // data low while clock high, then clock low
            if (tick)
            begin
               if (q.h == serial_port_pkg::STEP_ZERO)
               begin
                  n.sda_oe = 1'b1;
                  n.h = serial_port_pkg::STEP_ONE;
               end
               else
               begin
                  n.scl_oe = 1'b1;
                  n.sda_oe = 1'b0;
                  n.h = serial_port_pkg::STEP_ZERO;
                  n.fsm = serial_port_pkg::ST_I2C_BIT;
               end
            end
         end
         serial_port_pkg::ST_I2C_BIT:
         begin
            if (i2c_stop)
            begin
               n.stop_pend = 1'b1;
            end
            // an unread buffer keeps the clock low until software reads it
            if (q.h == serial_port_pkg::I2C_ACK_HALF && !q.byte_stored)
            begin
               if (!q.rx_full)
               begin
                  n.receive_buffer = q.rxsh;
                  n.rx_full = 1'b1;
                  n.byte_stored = 1'b1;
                  n.sda_oe = ~stop_now;
               end
            end
            else if (tick)
            begin
               n.h = q.h + serial_port_pkg::STEP_ONE;
               if (!q.h[0])
               begin
                  n.scl_oe = 1'b0;
               end
               else
               begin
                  n.scl_oe = 1'b1;
                  if (q.h < serial_port_pkg::I2C_ACK_HALF)
                  begin
                     n.rxsh = {q.rxsh[6:0], s[serial_port_pkg::SY_SDA]};
                  end
                  if (q.h == serial_port_pkg::I2C_LAST_HALF)
                  begin
                     n.h = serial_port_pkg::STEP_ZERO;
                     n.byte_stored = 1'b0;
                     n.sda_oe = stop_now;
                     if (stop_now)
                     begin
                        n.fsm = serial_port_pkg::ST_I2C_STOP;
                     end
                  end
               end
            end
         end
         serial_port_pkg::ST_I2C_STOP:
         begin
            // clock released first, then data rises
            if (tick)
            begin
               if (q.h == serial_port_pkg::STEP_ZERO)
               begin
                  n.scl_oe = 1'b0;
                  n.h = serial_port_pkg::STEP_ONE;
               end
               else
               begin
                  n.sda_oe = 1'b0;
                  n.fsm = serial_port_pkg::ST_IDLE;
               end
            end
         end
         default:
         begin
            n = serial_port_pkg::ST_RESET;
         end
      endcase
      // a write while loading keeps the new byte for the next transfer
      if (tx_write)
      begin
         n.txbuf = tx_data;
         n.txfull = 1'b1;
         n.tx_ready = 1'b0;
      end
      if (soft_reset_bit)
      begin
         n = serial_port_pkg::ST_RESET;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         q <= serial_port_pkg::ST_RESET;
      end
      else
      begin
         q <= n;
      end
   end

   // status and data from flops
   assign rx_data = q.receive_buffer;
   assign flags.tx_ready_flag = q.tx_ready;
   assign flags.rx_full_flag = q.rx_full;
   assign flags.port_busy_flag = q.fsm != serial_port_pkg::ST_IDLE || q.txfull;
   assign flags.tx_complete_flag = q.tx_cplt;
   assign flags.clk_line_low_flag = cfg.mode == serial_port_pkg::MODE_I2C_M &&
      !s[serial_port_pkg::SY_SCL];
   assign flags.rx_written_flag = q.rx_written;
   assign clk_request = flags.port_busy_flag;

   // pin drive; clock pin rests at the polarity level
   assign sck_out = q.phase ^ cfg.clock_polarity_sel;
   assign sck_oe = is_master;
   assign sdo = q.sdo;
   assign sdo_oe = is_master || (cfg.mode == serial_port_pkg::MODE_SPI_S && ste_act);
   assign slave_tx_enable_pin_out = (q.fsm == serial_port_pkg::ST_SPI) ?
      serial_port_pkg::STE_ACTIVE : ~serial_port_pkg::STE_ACTIVE;
   assign slave_tx_enable_pin_oe = cfg.mode == serial_port_pkg::MODE_SPI_M4 &&
      cfg.enable_pin_role_sel;
   assign scl_out = 1'b0;
   assign scl_oe = q.scl_oe;
   assign sda_out = 1'b0;
   assign sda_oe = q.sda_oe;
   assign uart_txd = q.txd;

endmodule

`default_nettype wire

// File: bench/serial_port_checker.sv
// Purpose: pin and flag assertions for the serial port
// Assumes: one core_clk domain, srst disables every check
// Notes: bit clock ticks are invisible here, so bounds are in core cycles
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker
(
   input wire logic core_clk,
   input wire logic srst,
   input wire serial_port_pkg::port_cfg_t cfg,
   input wire logic soft_reset_bit,
   input wire logic tx_write,
   input wire logic rx_read,
   input wire serial_port_pkg::port_flags_t flags,
   input wire logic clk_request,
   input wire logic slave_tx_enable_pin_in,
   input wire logic slave_tx_enable_pin_oe,
   input wire logic sck_out,
   input wire logic scl_oe,
   input wire logic uart_txd
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   a_idle_clk_level: assert property (
      !flags.port_busy_flag && $stable(cfg) |-> sck_out == cfg.clock_polarity_sel)
      else $error("sck away from idle level");
   a_soft_reset_idle: assert property (
      soft_reset_bit |=> flags.tx_ready_flag && !flags.port_busy_flag && !flags.rx_full_flag)
      else $error("soft reset left state behind");
   a_enable_pin_role: assert property (
      $stable(cfg) && !soft_reset_bit && !$past(soft_reset_bit) && !$past(srst)
      |-> slave_tx_enable_pin_oe == (cfg.mode == serial_port_pkg::MODE_SPI_M4
      && cfg.enable_pin_role_sel))
      else $error("enable pin drive wrong for role");
   a_guard_abort: assert property (
      (cfg.mode == serial_port_pkg::MODE_SPI_M4 && !cfg.enable_pin_role_sel
      && slave_tx_enable_pin_in) [*6] |-> sck_out == cfg.clock_polarity_sel)
      else $error("sck toggles while guard inactive");
   a_busy_clk_req: assert property (
      clk_request == flags.port_busy_flag)
      else $error("clock request differs from busy");
   a_write_takes: assert property (
      tx_write && !soft_reset_bit |=> !flags.tx_ready_flag)
      else $error("tx ready not cleared by write");
   a_read_clears: assert property (
      rx_read && !flags.port_busy_flag |=> !flags.rx_full_flag)
      else $error("rx full not cleared by read");
   a_stall_low_flag: assert property (
      (cfg.mode == serial_port_pkg::MODE_I2C_M && scl_oe) [*5] |-> flags.clk_line_low_flag)
      else $error("clock low flag missing");
   a_cplt_at_stop: assert property (
      $rose(flags.tx_complete_flag) |-> uart_txd && $past(uart_txd, 8))
      else $error("tx complete outside stop bit");

   // main scenarios reached
   c_rx_full: cover property ($rose(flags.rx_full_flag));
   c_tx_cplt: cover property ($rose(flags.tx_complete_flag));
   c_stall: cover property (flags.clk_line_low_flag [*8]);
endmodule
`default_nettype wire

// File: bench/spi_peer.sv
// Purpose: spi slave peer for the port's master modes
// Assumes: sel low between frames, sck idles at pol
// Notes: outside the eight bits miso shows the inverse of bit 0
`timescale 1ns/1ps
`default_nettype none
module spi_peer
(
   input wire logic sck,
   input wire logic pol,
   input wire logic pha,
   input wire logic sel,
   input wire logic mosi,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte
);
   int s = 0;
   int k;
   // select falling at frame end rewinds the shift count
   always @(negedge sel)
   begin
      s = 0;
   end
   // sample on leading edge for pha 0, on trailing edge for pha 1
   always @(sck)
   begin
      if (sel && ((sck != pol) ^ pha))
      begin
         rx_byte = {rx_byte[6:0], mosi};
      end
      else if (sel)
      begin
         s = s + 1;
      end
   end
   // never repeats the last bit, so a late sample cannot pass by luck
   always_comb
   begin
      k = s - int'(pha);
      miso = (k >= 0 && k < 8) ? tx_byte[7 - k] : ~tx_byte[0];
   end
endmodule
`default_nettype wire

// File: bench/serial_port_tb.sv
// Purpose: self-checking bench for the multi-mode serial port
// Assumes: spi peer on the data pins, pull-ups on both i2c lines
// Notes: aux and sub bit clocks run at 160 ns, offset from core_clk edges; the external clock input stays low
`timescale 1ns/1ps
`default_nettype none
module serial_port_tb;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic aux_clk = 1'b0;
   logic ext_run = 1'b0;
   serial_port_pkg::port_cfg_t cfg = '0;
   logic soft_reset_bit = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic tx_write = 1'b0;
   logic rx_read = 1'b0;
   logic tx_cplt_clr = 1'b0;
   logic i2c_start = 1'b0;
   logic i2c_stop = 1'b0;
   logic en_in = 1'b0;
   logic peer_sel = 1'b0;
   logic [7:0] peer_tx = 8'h00;
   logic tb_sck = 1'b0;
   logic tb_mosi = 1'b0;
   logic [7:0] sl_in = 8'h2D;
   logic [7:0] sl_got = 8'h00;
   logic [7:0] rx_data, peer_rx;
   serial_port_pkg::port_flags_t flags;
   logic clk_request, sck_out, sck_oe, sdo, sdo_oe, en_out, en_oe, miso;
   logic scl_out, scl_oe, sda_out, sda_oe, uart_txd;
   int err_count = 0;
   int num_checks = 0;
   int cyc_n = 0;
   // bench plays spi master in slave mode and keeps sck idle before soft reset ends
   wire logic sck_line = sck_oe ? sck_out : tb_sck;

   always #5 core_clk = ~core_clk;
   // odd offset keeps bit clock edges clear of core_clk edges
   initial
   begin
      #3;
      forever #80 aux_clk = ~aux_clk;
   end

   serial_port dut
   (
      .core_clk, .srst, .cfg, .soft_reset_bit, .tx_data, .tx_write, .rx_read, .tx_cplt_clr,
      .i2c_start, .i2c_stop, .rx_data, .flags, .clk_request, .aux_clk,
      .sub_main_clock(~aux_clk), .external_clock_input(aux_clk & ext_run), .sck_in(sck_line),
      .sck_out, .sck_oe, .sdi(sck_oe ? miso : tb_mosi), .sdo, .sdo_oe,
      .slave_tx_enable_pin_in(en_in),
      .slave_tx_enable_pin_out(en_out), .slave_tx_enable_pin_oe(en_oe), .scl_in(!scl_oe),
      .scl_out, .scl_oe, .sda_in(!sda_oe), .sda_out, .sda_oe, .uart_txd
   );

   spi_peer peer
   (
      .sck(sck_line), .pol(cfg.clock_polarity_sel), .pha(cfg.clock_phase_sel), .sel(peer_sel),
      .mosi(sdo), .tx_byte(peer_tx), .miso(miso), .rx_byte(peer_rx)
   );

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // bounded wait on one flag bit; a hang ends as a mismatch
   task automatic wt(input int b, input logic v);
      int k;
      k = 0;
      while (flags[b] !== v && k < 3000)
      begin
         @(posedge core_clk);
         k++;
      end
      chk(8'(flags[b]), 8'(v));
   endtask

   task automatic wr(input logic [7:0] b);
      tx_data <= b;
      tx_write <= 1'b1;
      cyc(1);
      tx_write <= 1'b0;
   endtask

   task automatic rd;
      rx_read <= 1'b1;
      cyc(1);
      rx_read <= 1'b0;
   endtask

   // one spi byte each way inside a peer frame
   task automatic xfer(input logic [7:0] b, input logic [7:0] r);
      peer_tx <= r;
      peer_sel <= 1'b1;
      cyc(2);
      wr(b);
      wt(4, 1'b1);
      chk(rx_data, r);
      wt(3, 1'b0);
      chk(peer_rx, b);
      rd;
      cyc(2);
      chk(8'(flags.rx_full_flag), 8'h00);
      peer_sel <= 1'b0;
   endtask

   // uart frame sampled mid-bit; a tick is 16 core cycles
   task automatic frame(input logic [7:0] b);
      logic [7:0] got;
      int k;
      k = 0;
      while (uart_txd !== 1'b0 && k < 3000)
      begin
         @(posedge core_clk);
         k++;
      end
      cyc(8);
      for (k = 0; k < 8; k++)
      begin
         cyc(16);
         got[k] = uart_txd;
      end
      chk(got, b);
      cyc(16);
      chk(8'(uart_txd), 8'h01);
   endtask

   // ceiling far above the four thousand or so cycles needed
   always @(posedge core_clk)
   begin
      cyc_n++;
      if (cyc_n == 40000)
      begin
         err_count++;
         test_done;
      end
   end

   initial
   begin
      cyc(5);
      srst <= 1'b0;
      cfg.enable_pin_role_sel <= 1'b1;
      cyc(3);
      chk({2'h0, flags}, 8'h20);
      chk(8'(uart_txd), 8'h01);
      $display("reset test done");
      for (int i = 0; i < 4; i++)
      begin
         cfg.mode <= i[1] ? serial_port_pkg::MODE_SPI_M4 : serial_port_pkg::MODE_SPI_M3;
         cfg.clock_polarity_sel <= i[1];
         cfg.clock_phase_sel <= i[0];
         cyc(3);
         chk(8'(sck_out), 8'(i[1]));
         xfer(8'hA5 ^ 8'(i), 8'h3C + 8'(i));
      end
      $display("spi modes test done");
      peer_sel <= 1'b1;
      wr(8'h81);
      cyc(60);
      chk(8'({en_oe, en_out}), 8'h02);
      soft_reset_bit <= 1'b1;
      cyc(2);
      soft_reset_bit <= 1'b0;
      peer_sel <= 1'b0;
      cyc(2);
      chk({2'h0, flags}, 8'h20);
      chk(8'(sck_out), 8'h01);
      xfer(8'h18, 8'hE7);
      $display("soft reset test done");
      cfg.enable_pin_role_sel <= 1'b0;
      peer_sel <= 1'b1;
      wr(8'h66);
      cyc(60);
      en_in <= 1'b1;
      cyc(300);
      chk({2'h0, flags}, 8'h20);
      chk(8'(sck_out), 8'h01);
      en_in <= 1'b0;
      peer_sel <= 1'b0;
      // let the peer see its select fall so its bit count restarts
      cyc(1);
      xfer(8'h66, 8'h99);
      $display("guard abort test done");
      cfg.mode <= serial_port_pkg::MODE_SPI_S;
      cfg.clock_polarity_sel <= 1'b0;
      cfg.clock_phase_sel <= 1'b0;
      soft_reset_bit <= 1'b1;
      cyc(3);
      soft_reset_bit <= 1'b0;
      cyc(3);
      wr(8'hB4);
      // bench clocks the slave: data set, leading edge samples, trailing edge shifts
      for (int j = 7; j >= 0; j--)
      begin
         tb_mosi <= sl_in[j];
         cyc(4);
         sl_got[j] = sdo;
         tb_sck <= 1'b1;
         cyc(8);
         tb_sck <= 1'b0;
         cyc(4);
      end
      wt(4, 1'b1);
      chk(rx_data, 8'h2D);
      chk(sl_got, 8'hB4);
      rd;
      cyc(2);
      $display("spi slave test done");
      cfg.mode <= serial_port_pkg::MODE_UART;
      cfg.clk_src <= serial_port_pkg::SRC_SUB;
      cyc(3);
      wr(8'h5A);
      cyc(4);
      wt(5, 1'b1);
      wr(8'hC3);
      frame(8'h5A);
      wt(2, 1'b1);
      tx_cplt_clr <= 1'b1;
      cyc(1);
      tx_cplt_clr <= 1'b0;
      cyc(2);
      chk(8'(flags.tx_complete_flag), 8'h00);
      frame(8'hC3);
      wt(2, 1'b1);
      $display("uart test done");
      cfg.mode <= serial_port_pkg::MODE_I2C_M;
      cfg.clk_src <= serial_port_pkg::SRC_EXT;
      cyc(3);
      i2c_start <= 1'b1;
      cyc(1);
      i2c_start <= 1'b0;
      wt(4, 1'b1);
      chk(rx_data, 8'hFF);
      chk(8'(flags.rx_written_flag), 8'h01);
      cyc(700);
      chk(8'(scl_oe), 8'h01);
      cyc(60);
      chk(8'({scl_oe, flags.clk_line_low_flag}), 8'h03);
      rd;
      cyc(1);
      chk(8'(flags.rx_written_flag), 8'h00);
      i2c_stop <= 1'b1;
      cyc(1);
      i2c_stop <= 1'b0;
      cyc(600);
      rd;
      wt(3, 1'b0);
      $display("i2c test done");
      test_done;
   end
endmodule

bind serial_port serial_port_checker chk_i
(
   .core_clk, .srst, .cfg, .soft_reset_bit, .tx_write, .rx_read, .flags, .clk_request,
   .slave_tx_enable_pin_in, .slave_tx_enable_pin_oe, .sck_out, .scl_oe, .uart_txd
);
`default_nettype wire
